// ===== dv/adcsc_core_model.sv
/*
 * Behavioural model of the analog conversion core beside the sequence control block.
 * Assumes one-cycle conversion requests and the single system clock of the block.
 */
`timescale 1ns/100ps
module adcsc_core_model #(
    parameter int DELAY = 6
) (
    // Clock and reset.
    input wire logic clock,
    input wire logic resetn,
    // Controller side.
    input wire logic conversion_request,
    input wire logic [3:0] input_channel_select,
    output logic conversion_done,
    output logic [11:0] conversion_result
);
    int count; // Cycles left in the running conversion, zero when idle.
    logic [3:0] chan; // Channel captured with the request.
    // The result carries the channel so routing shows; outside the done cycle it toggles, so a late read fails.
    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            count <= 0;
            chan <= 4'h0;
            conversion_done <= 1'b0;
            conversion_result <= 12'h000;
        end else begin
            conversion_done <= (count == 1);
            conversion_result <= (count == 1) ? {8'hC3, chan} : ~conversion_result;
            if (conversion_request) begin
                count <= DELAY;
                chan <= input_channel_select;
            end else if (count != 0) begin
                count <= count - 1;
            end
        end
    end
endmodule

// ===== dv/tb.sv
/*
 * Self-checking bench of the sequence control block: register access, locking, single conversions, a sequence.
 * Assumes the core model beside it; all expectations come from the register layout and the model's result.
 */
`timescale 1ns/100ps
module tb;
    import adcsc_pkg::*;
    logic clock = 1'b0;
    logic resetn = 1'b0;
    adcsc_bus_type bus = '0;
    adcsc_trig_type trig = '0;
    logic [3:0] tick = 4'hF; // Every source ticks each cycle, so sample lengths are exact counts.
    logic [15:0] rdata;
    logic done, req, samp;
    logic [11:0] res;
    logic [3:0] chan;
    logic [15:0] expq[$]; // Expected read data, oldest first.
    logic rd_d = 1'b0;
    logic [7:0] sc[16];
    logic [31:0] seed = 32'hBB6B;
    int n_errors = 0;
    int checked = 0;
    int cycles = 0;
    int len;
    always #25 clock = ~clock;
    adcsc_top dut (.clock(clock), .resetn(resetn), .bus(bus), .rdata(rdata), .trig(trig),
        .clock_source_tick(tick), .global_irq_enable(1'b1), .conversion_done(done), .conversion_result(res),
        .sampling_control(samp), .conversion_request(req), .converter_clock_tick(), .input_channel_select(chan),
        .reference_select(), .reference_generator_on(), .reference_level_select(), .converter_power_on(),
        .overwrite_irq_request(), .time_overflow_irq_request());
    adcsc_core_model core (.clock(clock), .resetn(resetn), .conversion_request(req),
        .input_channel_select(chan), .conversion_done(done), .conversion_result(res));
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(logic [15:0] a, logic [15:0] d);
        @(posedge clock);
        bus <= '{addr: a, wdata: d, write: 1'b1, read: 1'b0};
        @(posedge clock);
        bus <= '0;
    endtask
    task automatic rd(logic [15:0] a, logic [15:0] exp);
        @(posedge clock);
        bus <= '{addr: a, wdata: 16'h0000, write: 1'b0, read: 1'b1};
        expq.push_back(exp);
        @(posedge clock);
        bus <= '0;
    endtask
    // Watcher: read data stand only in the cycle after the strobe, so they are taken at the next edge.
    always @(posedge clock) begin
        if (rd_d) begin
            check("read data", rdata, expq.pop_front());
        end
        rd_d <= bus.read;
        trig <= 3'(rnd()); // Timer levels wander; the software trigger stays selected.
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            stop_test();
        end
    end
    task automatic stop_test();
        if (n_errors == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge clock);
        resetn <= 1'b1;
        rd(ADCSC_ADDR_CONTROL_PRIMARY, ADCSC_PRIMARY_RESET);
        rd(ADCSC_ADDR_CONTROL_SECONDARY, ADCSC_SECONDARY_RESET);
        rd(16'h01A4, 16'h0000);
        // Slot controls take any value while disabled.
        for (int i = 0; i < 16; i++) begin
            sc[i] = 8'(rnd());
            wr(ADCSC_ADDR_SLOT_CONTROL_BASE + 16'(i), {8'h00, sc[i]});
            rd(ADCSC_ADDR_SLOT_CONTROL_BASE + 16'(i), {8'h00, sc[i]});
        end
        // One single conversion from a lower slot and one from an upper slot, started by software.
        for (int k = 0; k < 2; k++) begin
            automatic logic [3:0] s = (k == 0) ? 4'h2 : 4'h9;
            wr(ADCSC_ADDR_CONTROL_PRIMARY, 16'h1010);
            wr(ADCSC_ADDR_CONTROL_SECONDARY, {s, 12'h200});
            wr(ADCSC_ADDR_CONTROL_PRIMARY, 16'h1013);
            len = 0;
            // Sampled mid-cycle, where the registered outputs have settled.
            for (int t = 0; t < 300 && !done; t++) begin
                @(negedge clock);
                len += samp;
            end
            check("sample length", 16'(len), (s > 7) ? 16'h0008 : 16'h0004);
            repeat (3) @(posedge clock);
            // Result slots are only read here, never written.
            rd(ADCSC_ADDR_RESULT_BASE + 16'(2 * s), {4'h0, 8'hC3, sc[s][3:0]});
            rd(ADCSC_ADDR_CONTROL_PRIMARY, 16'h1012);
            rd(ADCSC_ADDR_CONTROL_SECONDARY, {s, 12'h200});
            wr(ADCSC_ADDR_CONTROL_SECONDARY, 16'h0000);
            wr(ADCSC_ADDR_SLOT_CONTROL_BASE + 16'(s), {8'h00, ~sc[s]});
            // No start bit here: a stray conversion would still run into the next pass.
            wr(ADCSC_ADDR_CONTROL_PRIMARY, 16'h0F12);
            rd(ADCSC_ADDR_CONTROL_SECONDARY, {s, 12'h200});
            rd(ADCSC_ADDR_SLOT_CONTROL_BASE + 16'(s), {8'h00, sc[s]});
            rd(ADCSC_ADDR_CONTROL_PRIMARY, 16'h1012);
        end
        // Sequence once from slot three with multi-sample on; slot four carries the end mark.
        wr(ADCSC_ADDR_CONTROL_PRIMARY, 16'h1010);
        wr(ADCSC_ADDR_SLOT_CONTROL_BASE + 16'h0003, 16'h0005);
        wr(ADCSC_ADDR_SLOT_CONTROL_BASE + 16'h0004, 16'h0086);
        wr(ADCSC_ADDR_CONTROL_SECONDARY, 16'h3202);
        wr(ADCSC_ADDR_CONTROL_PRIMARY, 16'h1093);
        repeat (40) @(posedge clock);
        rd(ADCSC_ADDR_RESULT_BASE + 16'h0006, 16'h0C35);
        rd(ADCSC_ADDR_RESULT_BASE + 16'h0008, 16'h0C36);
        rd(ADCSC_ADDR_CONTROL_SECONDARY, 16'h3202);
        repeat (3) @(posedge clock);
        stop_test();
    end
endmodule

// ===== hdl/adcsc_pkg.sv
/*
 * Package for the converter sequence control block: register byte addresses, field positions,
 * write-lock masks, reset values, the controller state encoding and the state record.
 * Assumes a 16-bit register port with byte addresses and a single 20 MHz system clock.
 */
package adcsc_pkg;

    // Byte addresses of the registers on the plain register port.
    localparam logic [15:0] ADCSC_ADDR_CONTROL_PRIMARY = 16'h01A0;
    localparam logic [15:0] ADCSC_ADDR_CONTROL_SECONDARY = 16'h01A2;
    localparam logic [15:0] ADCSC_ADDR_RESULT_BASE = 16'h0140;
    localparam logic [15:0] ADCSC_ADDR_RESULT_LAST = 16'h015E;
    localparam logic [15:0] ADCSC_ADDR_SLOT_CONTROL_BASE = 16'h0080;
    localparam logic [15:0] ADCSC_ADDR_SLOT_CONTROL_LAST = 16'h008F;

    // Field positions in the primary control register.
    localparam int ADCSC_P_SHT_UPPER_LSB = 12;
    localparam int ADCSC_P_SHT_LOWER_LSB = 8;
    localparam int ADCSC_P_MULTI_SAMPLE = 7;
    localparam int ADCSC_P_REF_LEVEL = 6;
    localparam int ADCSC_P_REF_ON = 5;
    localparam int ADCSC_P_POWER_ON = 4;
    localparam int ADCSC_P_OVERWRITE_IE = 3;
    localparam int ADCSC_P_TIME_OVF_IE = 2;
    localparam int ADCSC_P_ENABLE = 1;
    localparam int ADCSC_P_SW_START = 0;

    // Field positions in the secondary control register.
    localparam int ADCSC_S_FIRST_SLOT_LSB = 12;
    localparam int ADCSC_S_TRIG_SRC_LSB = 10;
    localparam int ADCSC_S_PULSE_MODE = 9;
    localparam int ADCSC_S_TRIG_INVERT = 8;
    localparam int ADCSC_S_DIVIDE_LSB = 5;
    localparam int ADCSC_S_CLK_SRC_LSB = 3;
    localparam int ADCSC_S_SEQ_MODE_LSB = 1;
    localparam int ADCSC_S_ACTIVE = 0;

    // Field positions in a slot control byte.
    localparam int ADCSC_M_LAST_IN_SEQ = 7;
    localparam int ADCSC_M_REF_SEL_LSB = 4;

    // Bits that hold their value while conversion is enabled.
    localparam logic [15:0] ADCSC_PRIMARY_LOCK_MASK = 16'hFFE0;
    localparam logic [15:0] ADCSC_SECONDARY_LOCK_MASK = 16'hFFFE;

    // Values after reset.
    localparam logic [15:0] ADCSC_PRIMARY_RESET = 16'h0000;
    localparam logic [15:0] ADCSC_SECONDARY_RESET = 16'h0000;
    localparam logic [7:0] ADCSC_SLOT_CONTROL_RESET = 8'h00;

    // Sequence mode codes.
    localparam logic [1:0] ADCSC_MODE_SINGLE = 2'h0;
    localparam logic [1:0] ADCSC_MODE_SEQUENCE = 2'h1;
    localparam logic [1:0] ADCSC_MODE_REPEAT_SINGLE = 2'h2;
    localparam logic [1:0] ADCSC_MODE_REPEAT_SEQUENCE = 2'h3;

    // Controller states, one-hot.
    typedef enum logic [3:0] {
        ADCSC_IDLE = 4'h1,
        ADCSC_WAIT = 4'h2,
        ADCSC_SAMPLE = 4'h4,
        ADCSC_CONVERT = 4'h8
    } adcsc_fsm_type;

    // Register port request.
    typedef struct packed {
        logic [15:0] addr;
        logic [15:0] wdata;
        logic write;
        logic read;
    } adcsc_bus_type;

    // Timer trigger outputs; the converter clock source ticks come in on their own port.
    typedef struct packed {
        logic timer_a_out1;
        logic timer_b_out0;
        logic timer_b_out1;
    } adcsc_trig_type;

    // Whole state of the block.
    typedef struct packed {
        adcsc_fsm_type fsm;
        logic [15:0] control_primary;
        logic [15:1] control_secondary;
        logic [15:0][7:0] slot_control;
        logic [15:0][11:0] result;
        logic [15:0] unread;
        logic [3:0] slot;
        logic [10:0] timer;
        logic [2:0] div_count;
        logic conv_tick;
        logic prev_input;
        logic auto_start;
        logic in_sequence;
        logic active;
        logic sampling;
        logic conv_request;
        logic [3:0] channel;
        logic [2:0] reference;
        logic overwrite_irq;
        logic time_overflow_irq;
        logic [15:0] rdata;
    } adcsc_state_type;

endpackage

// ===== hdl/adcsc_top.sv
/*
 * Sequence control and result storage of a 12-bit successive-approximation converter.
 * Assumes the analog core takes a one-cycle conversion request and answers with a one-cycle
 * done pulse and the result, and that clock source ticks and timer outputs are synchronous.
 */
// Functional notes
// - Upper sample time serves slots eight to fifteen.
// - Lower sample time serves slots zero to seven.
// - Sample time code maps to converter clock counts.
// - Locked fields and slot controls change only disabled.
// - Multi sample: only first trigger edge needed.
// - Reference level valid only with generator on.
// - Overwrite request needs its enable and global enable.
// - Time overflow request needs enable and global.
// - Software start self clears, settable with enable.
// - First slot field picks starting result slot.
// - Trigger source field selects the sample input.
// - Pulse mode selects sampling timer over input.
// - Trigger invert bit inverts the sample input.
// - Converter clock divided by field plus one.
// - Clock source field picks one of four.
// - Four sequence modes in code order.
// - Active bit high while any operation runs.
// - Results right justified, top four bits zero.
// - Last in sequence bit ends a sequence.
// - Slot channel field routes the analog input.
`timescale 1ns/100ps
module adcsc_top (
    // System clock and reset.
    input wire logic clock,
    input wire logic resetn,
    // Register port.
    input wire adcsc_pkg::adcsc_bus_type bus,
    output logic [15:0] rdata,
    // Trigger sources, clock source ticks and the processor global interrupt enable.
    input wire adcsc_pkg::adcsc_trig_type trig,
    input wire logic [3:0] clock_source_tick,
    input wire logic global_irq_enable,
    // Analog core.
    input wire logic conversion_done,
    input wire logic [11:0] conversion_result,
    output logic sampling_control,
    output logic conversion_request,
    output logic converter_clock_tick,
    output logic [3:0] input_channel_select,
    output logic [2:0] reference_select,
    output logic reference_generator_on,
    output logic reference_level_select,
    output logic converter_power_on,
    // Interrupt requests towards the vector logic.
    output logic overwrite_irq_request,
    output logic time_overflow_irq_request
);
    import adcsc_pkg::*;

    // Current and next state record.
    adcsc_state_type st;
    adcsc_state_type next_st;

    // Decoded helpers derived from the current state.
    logic enabled;
    logic sample_input;
    logic rising;
    logic [10:0] limit;
    logic [1:0] mode;
    logic [3:0] first_slot;
    logic [7:0] cur_ctl;

    // Maps a sample-time code onto converter clock counts; codes above eleven saturate.
    function automatic logic [10:0] sample_cycles(input logic [3:0] code);
        logic [10:0] n;
        n = 11'h400;
        case (code)
            4'h0: n = 11'h004;
            4'h1: n = 11'h008;
            4'h2: n = 11'h010;
            4'h3: n = 11'h020;
            4'h4: n = 11'h040;
            4'h5: n = 11'h060;
            4'h6: n = 11'h080;
            4'h7: n = 11'h0C0;
            4'h8: n = 11'h100;
            4'h9: n = 11'h180;
            4'hA: n = 11'h200;
            4'hB: n = 11'h300;
            default: n = 11'h400;
        endcase
        return n;
    endfunction

    // Trigger selection, polarity and edge detection are pure decode of the timer inputs and the stored state.
    always_comb begin
        enabled = st.control_primary[ADCSC_P_ENABLE];
        mode = st.control_secondary[ADCSC_S_SEQ_MODE_LSB +: 2];
        first_slot = st.control_secondary[ADCSC_S_FIRST_SLOT_LSB +: 4];
        cur_ctl = st.slot_control[st.slot];
        // The software start bit is itself a one-cycle level, so it yields exactly one edge.
        case (st.control_secondary[ADCSC_S_TRIG_SRC_LSB +: 2])
            2'h0: sample_input = st.control_primary[ADCSC_P_SW_START];
            2'h1: sample_input = trig.timer_a_out1;
            2'h2: sample_input = trig.timer_b_out0;
            default: sample_input = trig.timer_b_out1;
        endcase
        sample_input = sample_input ^ st.control_secondary[ADCSC_S_TRIG_INVERT];
        rising = sample_input && !st.prev_input;
        // Slots eight and up use the upper field, the rest the lower one.
        if (st.slot[3]) begin
            limit = sample_cycles(st.control_primary[ADCSC_P_SHT_UPPER_LSB +: 4]);
        end else begin
            limit = sample_cycles(st.control_primary[ADCSC_P_SHT_LOWER_LSB +: 4]);
        end
    end

    // Next-state logic: register port, clock divider, sequencer and event requests.
    always_comb begin
        logic [3:0] idx;
        logic [15:0] wval;
        logic last;
        logic goes_on;
        idx = 4'h0;
        wval = 16'h0000;
        last = 1'b0;
        goes_on = 1'b0;
        next_st = st;
        next_st.prev_input = sample_input;
        next_st.conv_request = 1'b0;
        next_st.overwrite_irq = 1'b0;
        next_st.time_overflow_irq = 1'b0;
        next_st.conv_tick = 1'b0;
        next_st.rdata = 16'h0000;
        // The start bit lives for one cycle only.
        next_st.control_primary[ADCSC_P_SW_START] = 1'b0;

        // Divider counts ticks of the selected source and emits one tick per wrap.
        if (clock_source_tick[st.control_secondary[ADCSC_S_CLK_SRC_LSB +: 2]]) begin
            if (st.div_count == st.control_secondary[ADCSC_S_DIVIDE_LSB +: 3]) begin
                next_st.div_count = 3'h0;
                next_st.conv_tick = 1'b1;
            end else begin
                next_st.div_count = st.div_count + 3'h1;
            end
        end

        // Sequencer.
        case (st.fsm)
            ADCSC_IDLE: begin
                next_st.sampling = 1'b0;
                if (enabled) begin
                    next_st.fsm = ADCSC_WAIT;
                    next_st.slot = first_slot;
                    // Enable and start may come in one write, so the edge that they make is taken here too.
                    if (rising) begin
                        next_st.fsm = ADCSC_SAMPLE;
                        next_st.sampling = 1'b1;
                        next_st.timer = 11'h000;
                        next_st.auto_start = 1'b0;
                        next_st.channel = st.slot_control[first_slot][3:0];
                        next_st.reference = st.slot_control[first_slot][ADCSC_M_REF_SEL_LSB +: 3];
                    end
                end
            end
            ADCSC_WAIT: begin
                if (!enabled) begin
                    // Disabling between conversions abandons the rest of a sequence.
                    next_st.fsm = ADCSC_IDLE;
                    next_st.in_sequence = 1'b0;
                end else if (rising) begin
                    next_st.fsm = ADCSC_SAMPLE;
                    next_st.sampling = 1'b1;
                    next_st.timer = 11'h000;
                    next_st.auto_start = 1'b0;
                    next_st.channel = cur_ctl[3:0];
                    next_st.reference = cur_ctl[ADCSC_M_REF_SEL_LSB +: 3];
                end
            end
            ADCSC_SAMPLE: begin
                // Timed sampling in pulse mode or after an automatic start, else follow the input.
                if (st.control_secondary[ADCSC_S_PULSE_MODE] || st.auto_start) begin
                    if (st.conv_tick) begin
                        if (st.timer + 11'h001 >= limit) begin
                            next_st.fsm = ADCSC_CONVERT;
                            next_st.sampling = 1'b0;
                            next_st.conv_request = 1'b1;
                        end else begin
                            next_st.timer = st.timer + 11'h001;
                        end
                    end
                end else if (!sample_input) begin
                    next_st.fsm = ADCSC_CONVERT;
                    next_st.sampling = 1'b0;
                    next_st.conv_request = 1'b1;
                end
            end
            ADCSC_CONVERT: begin
                if (conversion_done) begin
                    last = cur_ctl[ADCSC_M_LAST_IN_SEQ];
                    // Modes: single once, sequence once, repeat single, repeat sequence.
                    case (mode)
                        ADCSC_MODE_SEQUENCE: begin
                            next_st.slot = last ? first_slot : st.slot + 4'h1;
                            goes_on = !last;
                        end
                        ADCSC_MODE_REPEAT_SINGLE: begin
                            goes_on = 1'b1;
                        end
                        ADCSC_MODE_REPEAT_SEQUENCE: begin
                            next_st.slot = last ? first_slot : st.slot + 4'h1;
                            goes_on = 1'b1;
                        end
                        default: begin
                            goes_on = 1'b0;
                        end
                    endcase
                    next_st.in_sequence = (mode == ADCSC_MODE_SEQUENCE || mode == ADCSC_MODE_REPEAT_SEQUENCE) && !last;
                    if (goes_on && enabled && st.control_primary[ADCSC_P_MULTI_SAMPLE]) begin
                        // Multi-sample: next sample starts without a new trigger edge.
                        next_st.fsm = ADCSC_SAMPLE;
                        next_st.sampling = 1'b1;
                        next_st.timer = 11'h000;
                        next_st.auto_start = 1'b1;
                        next_st.channel = st.slot_control[next_st.slot][3:0];
                        next_st.reference = st.slot_control[next_st.slot][ADCSC_M_REF_SEL_LSB +: 3];
                    end else begin
                        next_st.fsm = ADCSC_WAIT;
                    end
                end
            end
            default: begin
                next_st.fsm = ADCSC_IDLE;
            end
        endcase

        // A trigger edge during an ongoing sample or conversion is a timing overflow.
        if (rising && (st.fsm == ADCSC_SAMPLE || st.fsm == ADCSC_CONVERT)) begin
            next_st.time_overflow_irq = st.control_primary[ADCSC_P_TIME_OVF_IE] && global_irq_enable;
        end

        // Register port; an unmapped read returns zero.
        if (bus.write || bus.read) begin
            if (bus.addr == ADCSC_ADDR_CONTROL_PRIMARY) begin
                next_st.rdata = st.control_primary;
                if (bus.write) begin
                    wval = bus.wdata;
                    if (enabled) begin
                        // Locked bits keep their value, no error is raised.
                        wval = (st.control_primary & ADCSC_PRIMARY_LOCK_MASK)
                            | (bus.wdata & ~ADCSC_PRIMARY_LOCK_MASK);
                    end
                    next_st.control_primary = wval;
                end
            end else if (bus.addr == ADCSC_ADDR_CONTROL_SECONDARY) begin
                next_st.rdata = {st.control_secondary, st.active};
                if (bus.write && !enabled) begin
                    next_st.control_secondary = bus.wdata[15:1];
                end
            end else if (bus.addr >= ADCSC_ADDR_RESULT_BASE && bus.addr <= ADCSC_ADDR_RESULT_LAST
                && !bus.addr[0]) begin
                idx = bus.addr[4:1];
                next_st.rdata = {4'h0, st.result[idx]};
                next_st.unread[idx] = 1'b0;
                if (bus.write) begin
                    // Software writing here overwrites a stored result.
                    next_st.result[idx] = bus.wdata[11:0];
                end
            end else if (bus.addr >= ADCSC_ADDR_SLOT_CONTROL_BASE && bus.addr <= ADCSC_ADDR_SLOT_CONTROL_LAST) begin
                idx = bus.addr[3:0];
                next_st.rdata = {8'h00, st.slot_control[idx]};
                if (bus.write && !enabled) begin
                    next_st.slot_control[idx] = bus.wdata[7:0];
                end
            end
        end

        // Result store comes last so a new result wins over a same-cycle read or write.
        if (st.fsm == ADCSC_CONVERT && conversion_done) begin
            next_st.result[st.slot] = conversion_result;
            next_st.unread[st.slot] = 1'b1;
            if (st.unread[st.slot]) begin
                next_st.overwrite_irq = st.control_primary[ADCSC_P_OVERWRITE_IE] && global_irq_enable;
            end
        end

        next_st.active = (next_st.fsm == ADCSC_SAMPLE) || (next_st.fsm == ADCSC_CONVERT)
            || next_st.in_sequence;
    end

    // State register; asynchronous reset loads constants only.
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            st <= '0;
            st.fsm <= ADCSC_IDLE;
            st.control_primary <= ADCSC_PRIMARY_RESET;
            st.control_secondary <= ADCSC_SECONDARY_RESET[15:1];
            st.slot_control <= {16{ADCSC_SLOT_CONTROL_RESET}};
        end else begin
            st <= next_st;
        end
    end

    // Outputs are flip-flop fields of the state record, except the level select, which is gated below.
    assign rdata = st.rdata;
    assign sampling_control = st.sampling;
    assign conversion_request = st.conv_request;
    assign converter_clock_tick = st.conv_tick;
    assign input_channel_select = st.channel;
    assign reference_select = st.reference;
    assign reference_generator_on = st.control_primary[ADCSC_P_REF_ON];
    // Level select is masked here; with the generator off the choice would be meaningless.
    assign reference_level_select = st.control_primary[ADCSC_P_REF_LEVEL]
        && st.control_primary[ADCSC_P_REF_ON];
    assign converter_power_on = st.control_primary[ADCSC_P_POWER_ON];
    assign overwrite_irq_request = st.overwrite_irq;
    assign time_overflow_irq_request = st.time_overflow_irq;

    // Checks on the behaviour above.
    property p_start_clears;
        @(posedge clock) disable iff (!resetn)
        st.control_primary[ADCSC_P_SW_START] && !(bus.write && bus.addr == ADCSC_ADDR_CONTROL_PRIMARY)
        |=> !st.control_primary[ADCSC_P_SW_START];
    endproperty
    a_start_clears: assert property (p_start_clears) else $error("start bit did not clear");

    property p_secondary_locked;
        @(posedge clock) disable iff (!resetn)
        bus.write && bus.addr == ADCSC_ADDR_CONTROL_SECONDARY && enabled |=> $stable(st.control_secondary);
    endproperty
    a_secondary_locked: assert property (p_secondary_locked) else $error("locked field changed");

    property p_primary_locked;
        @(posedge clock) disable iff (!resetn)
        bus.write && bus.addr == ADCSC_ADDR_CONTROL_PRIMARY && enabled
        |=> (st.control_primary & ADCSC_PRIMARY_LOCK_MASK) == $past(st.control_primary & ADCSC_PRIMARY_LOCK_MASK);
    endproperty
    a_primary_locked: assert property (p_primary_locked) else $error("locked field changed");

    property p_result_justified;
        @(posedge clock) disable iff (!resetn)
        bus.read && bus.addr >= ADCSC_ADDR_RESULT_BASE && bus.addr <= ADCSC_ADDR_RESULT_LAST |=> rdata[15:12] == 4'h0;
    endproperty
    a_result_justified: assert property (p_result_justified) else $error("result upper bits not zero");

    property p_overwrite_gated;
        @(posedge clock) disable iff (!resetn)
        overwrite_irq_request |-> $past(st.control_primary[ADCSC_P_OVERWRITE_IE] && global_irq_enable);
    endproperty
    a_overwrite_gated: assert property (p_overwrite_gated) else $error("overwrite request not enabled");

    property p_timeovf_gated;
        @(posedge clock) disable iff (!resetn)
        time_overflow_irq_request |-> $past(st.control_primary[ADCSC_P_TIME_OVF_IE] && global_irq_enable);
    endproperty
    a_timeovf_gated: assert property (p_timeovf_gated) else $error("time overflow request not enabled");

    property p_pulse_min_sample;
        @(posedge clock) disable iff (!resetn)
        $rose(sampling_control) && st.control_secondary[ADCSC_S_PULSE_MODE] |-> sampling_control [*4];
    endproperty
    a_pulse_min_sample: assert property (p_pulse_min_sample) else $error("sample shorter than four");

    property p_active_during_sample;
        @(posedge clock) disable iff (!resetn)
        st.fsm == ADCSC_SAMPLE || st.fsm == ADCSC_CONVERT |-> st.active;
    endproperty
    a_active_during_sample: assert property (p_active_during_sample) else $error("busy flag low");

    property p_sequence_ends;
        @(posedge clock) disable iff (!resetn)
        st.fsm == ADCSC_CONVERT && conversion_done && cur_ctl[ADCSC_M_LAST_IN_SEQ] && mode == ADCSC_MODE_SEQUENCE
        |=> st.fsm == ADCSC_WAIT && st.slot == first_slot && !st.active;
    endproperty
    a_sequence_ends: assert property (p_sequence_ends) else $error("sequence did not end");

endmodule
